// ---- rtl/bstap_params.svh ----
`ifndef BSTAP_PARAMS_SVH
`define BSTAP_PARAMS_SVH

// instruction width and codes
`define BSTAP_IR_W 3
`define BSTAP_OP_EXTEST 3'h0
`define BSTAP_OP_IDCODE 3'h1
`define BSTAP_OP_SAMPLE 3'h2
`define BSTAP_OP_CLAMP 3'h3
`define BSTAP_OP_HIGHZ 3'h4
`define BSTAP_OP_BYPASS 3'h7
// fixed value loaded in capture-ir, low two bits 01
`define BSTAP_IR_CAPTURE 3'h1
// data register lengths
`define BSTAP_BSR_LEN 126
`define BSTAP_ID_LEN 32
// identification code field widths
`define BSTAP_ID_MFR_W 11
`define BSTAP_ID_DEV_W 16
`define BSTAP_ID_VER_W 4

`endif

// ---- rtl/bstap_pkg.sv ----
package bstap_pkg;

    // sixteen controller states
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE,
        ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
        ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
    } bstap_state_t;

    // which data register sits on the scan path
    typedef enum logic [1:0] {
        SEL_BYPASS, SEL_BOUNDARY, SEL_IDENT
    } bstap_sel_t;

endpackage : bstap_pkg

// ---- rtl/bstap_sync.sv ----
`timescale 1ns/1ps
// two-stage synchroniser for one level from outside the clock domain
module bstap_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // level in and out
    input wire logic async_i,
    output logic sync_o
);
    logic meta;

    // first stage feeds only the second
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta <= RESET_VAL;
            sync_o <= RESET_VAL;
        end else begin
            meta <= async_i;
            sync_o <= meta;
        end
    end
endmodule : bstap_sync

// ---- rtl/bstap_tap.sv ----
`timescale 1ns/1ps
`include "bstap_params.svh"

// Behaviour
// R1 - controller samples mode select and changes state only at rising test clock
// R2 - after reset: test-logic-reset state, idcode current, system logic normal
// R3 - select-dr: low enters capture-dr, high enters select-ir; registers hold
// R4 - capture-dr loads selected register if allowed; low shift-dr, high exit1-dr
// R5 - shift-dr: selected register between data in and out, one stage per edge
// R6 - shift-dr: high goes to exit1-dr, low keeps shifting
// R7 - exit1-dr: high update-dr, low pause-dr; pause holds until high to exit2-dr
// R8 - exit2-dr: high goes to update-dr, low returns to shift-dr
// R9 - update-dr falling edge copies shift stages into parallel output latches
// R10 - from either update state: low to run-test-idle, high to select-dr
// R11 - select-ir: low enters capture-ir, high returns to test-logic-reset
// R12 - capture-ir loads a fixed constant; high exit1-ir, low shift-ir
// R13 - captured instruction constant ends in binary 01
// R14 - shift-ir: instruction stages shift between data in and out; others hold
// R15 - exit1-ir or exit2-ir high to update-ir; low pause-ir or shift-ir
// R16 - pause-ir: stay while low, high goes to exit2-ir
// R17 - update-ir falling edge latches instruction, which becomes current
// R18 - instruction register: three-bit shift section plus latched parallel output
// R19 - decode 010 sample, 111 bypass, 000 extest, 011 clamp, 100 highz, 001 idcode
// R20 - sample/preload captures pins and preloads boundary register serially
// R21 - extest drives output pins from boundary latches, captures inputs
// R22 - bypass puts a single-stage register on the scan path
// R23 - idcode loads at capture-dr and shifts out; reset state forces idcode
// R24 - id code: bit0 one, 11-bit maker, 16-bit device, 4-bit version
// R25 - highz floats all digital outputs, bypass on scan path
// R26 - clamp drives outputs from boundary latches, bypass on scan path
// R27 - boundary register has shift path and latched outputs, 126 stages
// R28 - identification register 32 bits, shift and latched output
// R29 - test reset low forces test-logic-reset and idcode asynchronously; here it is synchronised to mclk_i first
module bstap_tap
    import bstap_pkg::*;
#(
    parameter int BSR_LEN = `BSTAP_BSR_LEN,
    parameter logic [`BSTAP_ID_VER_W-1:0] ID_VERSION = 4'h1, // arbitrary value
    parameter logic [`BSTAP_ID_DEV_W-1:0] ID_DEVICE = 16'hA5C3, // arbitrary value
    parameter logic [`BSTAP_ID_MFR_W-1:0] ID_MAKER = 11'h2B6 // arbitrary value
) (
    // system clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // test access pins; inputs asynchronous to mclk_i, serial out and its enable registered on mclk_i
    input wire logic test_reset_n_i,
    input wire logic test_clock_in_i,
    input wire logic test_mode_select_i,
    input wire logic test_serial_in_i,
    output logic test_serial_out_o,
    output logic test_serial_out_oe_o,
    // boundary cells: pin sample in, core value in, pin value and enable out
    input wire logic [BSR_LEN-1:0] pin_sample_i,
    input wire logic [BSR_LEN-1:0] core_out_i,
    input wire logic core_oe_i,
    output logic [BSR_LEN-1:0] pin_out_o,
    output logic pin_oe_o,
    // status
    output logic [`BSTAP_IR_W-1:0] instr_o,
    output logic in_reset_state_o
);
    // refuse a boundary register too short for the shift slice below
    if (BSR_LEN < 2) begin : g_bad_len
        $error("BSR_LEN must be at least 2");
    end

    // synchronised pins
    logic trst_n_s;
    logic tck_s;
    logic tms_s;
    logic tdi_s;
    logic tck_d;
    logic rise;
    logic fall;

    bstap_sync #(.RESET_VAL(1'b0)) u_sync_trst (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i),
        .async_i(test_reset_n_i), .sync_o(trst_n_s)
    );
    bstap_sync #(.RESET_VAL(1'b0)) u_sync_tck (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i),
        .async_i(test_clock_in_i), .sync_o(tck_s)
    );
    bstap_sync #(.RESET_VAL(1'b1)) u_sync_tms (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i),
        .async_i(test_mode_select_i), .sync_o(tms_s)
    );
    bstap_sync #(.RESET_VAL(1'b1)) u_sync_tdi (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i),
        .async_i(test_serial_in_i), .sync_o(tdi_s)
    );

    // pin levels are independent samples, so a bit caught mid-change is still a valid level
    logic [BSR_LEN-1:0] pin_meta;
    logic [BSR_LEN-1:0] pin_sync;
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= pin_sample_i;
            pin_sync <= pin_meta;
        end
    end

    // edge detect on the synchronised test clock
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tck_d <= 1'b0;
        end else begin
            tck_d <= tck_s;
        end
    end
    assign rise = tck_s & ~tck_d;
    assign fall = ~tck_s & tck_d;

    // test reset is sampled, so its effect lags the pin by the sync delay
    logic trst_act;
    assign trst_act = ~trst_n_s;

    bstap_state_t state;
    bstap_state_t next_state;

    // next-state table
    always_comb begin
        next_state = state;
        unique case (state)
            ST_RESET: next_state = tms_s ? ST_RESET : ST_IDLE;
            ST_IDLE: next_state = tms_s ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: next_state = tms_s ? ST_SEL_IR : ST_CAP_DR; // see R3
            ST_CAP_DR: next_state = tms_s ? ST_EX1_DR : ST_SH_DR; // see R4
            ST_SH_DR: next_state = tms_s ? ST_EX1_DR : ST_SH_DR; // see R6
            ST_EX1_DR: next_state = tms_s ? ST_UPD_DR : ST_PAU_DR; // see R7
            ST_PAU_DR: next_state = tms_s ? ST_EX2_DR : ST_PAU_DR; // see R7
            ST_EX2_DR: next_state = tms_s ? ST_UPD_DR : ST_SH_DR; // see R8
            ST_UPD_DR: next_state = tms_s ? ST_SEL_DR : ST_IDLE; // see R10
            ST_SEL_IR: next_state = tms_s ? ST_RESET : ST_CAP_IR; // see R11
            ST_CAP_IR: next_state = tms_s ? ST_EX1_IR : ST_SH_IR; // see R12
            ST_SH_IR: next_state = tms_s ? ST_EX1_IR : ST_SH_IR; // see R14
            ST_EX1_IR: next_state = tms_s ? ST_UPD_IR : ST_PAU_IR; // see R15
            ST_PAU_IR: next_state = tms_s ? ST_EX2_IR : ST_PAU_IR; // see R16
            ST_EX2_IR: next_state = tms_s ? ST_UPD_IR : ST_SH_IR; // see R15
            ST_UPD_IR: next_state = tms_s ? ST_SEL_DR : ST_IDLE; // see R10
        endcase
    end

    // state register moves on a test clock rising edge, or to test-logic-reset whenever test reset is active
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= ST_RESET; // see R2
        end else if (trst_act) begin
            state <= ST_RESET; // see R29
        end else if (rise) begin
            state <= next_state; // see R1
        end
    end

    // instruction register: shift section and latched output
    logic [`BSTAP_IR_W-1:0] ir_shift;
    logic [`BSTAP_IR_W-1:0] ir_cur;

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ir_shift <= `BSTAP_IR_CAPTURE;
        end else if (rise && state == ST_CAP_IR) begin
            ir_shift <= `BSTAP_IR_CAPTURE; // see R12, R13
        end else if (rise && state == ST_SH_IR) begin
            ir_shift <= {tdi_s, ir_shift[`BSTAP_IR_W-1:1]}; // see R14, R18
        end
    end

    // latched on the falling edge once update-ir is reached
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ir_cur <= `BSTAP_OP_IDCODE; // see R2
        end else if (trst_act || state == ST_RESET) begin
            ir_cur <= `BSTAP_OP_IDCODE; // see R23, R29
        end else if (fall && state == ST_UPD_IR) begin
            ir_cur <= ir_shift; // see R17
        end
    end

    // instruction decode; unknown codes fall back to bypass
    bstap_sel_t sel;
    logic drive_bsr;
    logic float_out;
    always_comb begin
        sel = SEL_BYPASS; // see R22, R25, R26
        drive_bsr = 1'b0;
        float_out = 1'b0;
        unique case (ir_cur) // see R19
            `BSTAP_OP_SAMPLE: sel = SEL_BOUNDARY; // see R20
            `BSTAP_OP_EXTEST: begin
                sel = SEL_BOUNDARY;
                drive_bsr = 1'b1; // see R21
            end
            `BSTAP_OP_CLAMP: drive_bsr = 1'b1; // see R26
            `BSTAP_OP_HIGHZ: float_out = 1'b1; // see R25
            `BSTAP_OP_IDCODE: sel = SEL_IDENT; // see R23, R28
            default: sel = SEL_BYPASS;
        endcase
    end

    // identification value, bit0 fixed at one
    localparam logic [`BSTAP_ID_LEN-1:0] ID_CODE =
        {ID_VERSION, ID_DEVICE, ID_MAKER, 1'b1}; // see R24

    // data registers
    logic bypass_bit;
    logic [`BSTAP_ID_LEN-1:0] id_shift;
    logic [`BSTAP_ID_LEN-1:0] id_latch;
    logic [BSR_LEN-1:0] bsr_shift;
    logic [BSR_LEN-1:0] bsr_latch;
    logic cap_dr;
    logic sh_dr;
    assign cap_dr = rise && state == ST_CAP_DR;
    assign sh_dr = rise && state == ST_SH_DR;

    // bypass stage captures zero as usual
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bypass_bit <= 1'b0;
        end else if (sel == SEL_BYPASS && cap_dr) begin
            bypass_bit <= 1'b0;
        end else if (sel == SEL_BYPASS && sh_dr) begin
            bypass_bit <= tdi_s; // see R22
        end
    end

    // identification register
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            id_shift <= '0;
        end else if (sel == SEL_IDENT && cap_dr) begin
            id_shift <= ID_CODE; // see R23
        end else if (sel == SEL_IDENT && sh_dr) begin
            id_shift <= {tdi_s, id_shift[`BSTAP_ID_LEN-1:1]}; // see R5
        end
    end

    // boundary register shift path; unselected registers hold
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bsr_shift <= '0;
        end else if (sel == SEL_BOUNDARY && cap_dr) begin
            bsr_shift <= pin_sync; // see R4, R20, R21
        end else if (sel == SEL_BOUNDARY && sh_dr) begin
            bsr_shift <= {tdi_s, bsr_shift[BSR_LEN-1:1]}; // see R5, R27
        end
    end

    // parallel latches update at the falling edge in update-dr only
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bsr_latch <= '0;
            id_latch <= '0;
        end else if (fall && state == ST_UPD_DR) begin
            if (sel == SEL_BOUNDARY) begin
                bsr_latch <= bsr_shift; // see R9, R27
            end
            if (sel == SEL_IDENT) begin
                id_latch <= id_shift; // see R28
            end
        end
    end

    // serial out changes on the falling edge, the usual tap convention
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            test_serial_out_o <= 1'b0;
            test_serial_out_oe_o <= 1'b0;
        end else if (fall) begin
            test_serial_out_oe_o <= (state == ST_SH_DR) || (state == ST_SH_IR);
            if (state == ST_SH_IR) begin
                test_serial_out_o <= ir_shift[0]; // see R14
            end else begin
                unique case (sel)
                    SEL_BOUNDARY: test_serial_out_o <= bsr_shift[0];
                    SEL_IDENT: test_serial_out_o <= id_shift[0];
                    default: test_serial_out_o <= bypass_bit;
                endcase
            end
        end
    end

    // pin muxing: normal path unless a test instruction owns the pins
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_out_o <= '0;
            pin_oe_o <= 1'b0;
        end else begin
            pin_out_o <= drive_bsr ? bsr_latch : core_out_i; // see R21, R26
            pin_oe_o <= float_out ? 1'b0 : (drive_bsr ? 1'b1 : core_oe_i); // see R25
        end
    end

    // status outputs
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            instr_o <= `BSTAP_OP_IDCODE;
            in_reset_state_o <= 1'b1;
        end else begin
            instr_o <= ir_cur;
            in_reset_state_o <= (state == ST_RESET);
        end
    end

    a_ir_capture_const: assert property ( // see R13
        @(posedge mclk_i) disable iff (!rst_b_i)
        (rise && state == ST_CAP_IR && !trst_act) |=> ir_shift[1:0] == 2'h1
    ) else $error("capture-ir did not load 01");

    a_sel_ir_exit: assert property ( // see R11
        @(posedge mclk_i) disable iff (!rst_b_i)
        (rise && state == ST_SEL_IR && tms_s) |=> state == ST_RESET
    ) else $error("select-ir with high mode did not reset");

    a_state_hold: assert property ( // see R1
        @(posedge mclk_i) disable iff (!rst_b_i)
        (!rise && !trst_act) |=> $stable(state)
    ) else $error("state changed without test clock rise");

    a_reset_idcode: assert property ( // see R23
        @(posedge mclk_i) disable iff (!rst_b_i)
        state == ST_RESET |=> ir_cur == `BSTAP_OP_IDCODE
    ) else $error("reset state did not force idcode");

    a_trst_force: assert property ( // see R29
        @(posedge mclk_i) disable iff (!rst_b_i)
        trst_act |=> state == ST_RESET ##1 ir_cur == `BSTAP_OP_IDCODE
    ) else $error("test reset did not force reset state");

    a_id_capture: assert property ( // see R24
        @(posedge mclk_i) disable iff (!rst_b_i)
        (cap_dr && sel == SEL_IDENT) |=> id_shift[0] == 1'b1
    ) else $error("id capture missing fixed one");

    a_highz_float: assert property ( // see R25
        @(posedge mclk_i) disable iff (!rst_b_i)
        (ir_cur == `BSTAP_OP_HIGHZ) [*2] |=> !pin_oe_o
    ) else $error("highz did not float outputs");

    a_clamp_stable: assert property ( // see R26
        @(posedge mclk_i) disable iff (!rst_b_i)
        (ir_cur == `BSTAP_OP_CLAMP && $past(ir_cur) == `BSTAP_OP_CLAMP)
            |=> pin_out_o == $past(bsr_latch)
    ) else $error("clamp outputs not from boundary latches");

    a_latch_quiet: assert property ( // see R9
        @(posedge mclk_i) disable iff (!rst_b_i)
        !(fall && state == ST_UPD_DR) |=> $stable(bsr_latch)
    ) else $error("boundary latch moved outside update-dr");

    a_ir_update: assert property ( // see R17
        @(posedge mclk_i) disable iff (!rst_b_i)
        (fall && state == ST_UPD_IR && !trst_act) |=> ir_cur == $past(ir_shift)
    ) else $error("update-ir did not latch instruction");

    a_id_latch_load: assert property ( // see R28
        @(posedge mclk_i) disable iff (!rst_b_i)
        (fall && state == ST_UPD_DR && sel == SEL_IDENT) |=> id_latch == $past(id_shift)
    ) else $error("id latch did not take shift stages");

endmodule : bstap_tap

// ---- verif/bstap_jtag_model.sv ----
`timescale 1ns/1ps
// behavioural scan controller on the far side of the test access pins
module bstap_jtag_model (
    // scan pins towards the block
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    output logic trst_n_o,
    // serial data back from the block
    input wire logic tdo_i,
    input wire logic tdo_oe_i
);
    // test clock rests low between frames, reset released
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
        trst_n_o = 1'b1;
    end

    // one 160 ns test clock period; started 1 ns past a system clock edge, every pin
    // change stays 1 ns past an edge; select and data hold well past the sampled rise
    task automatic bit_cyc(input logic ms, input logic di, output logic do_v);
        tms_o = ms;
        tdi_o = di;
        #80;
        tck_o = 1'b1;
        #40;
        // released data line must not look like the last bit
        tdi_o = ~di;
        #39;
        // sampled before the fall: serial out only moves after the fall is seen
        do_v = tdo_oe_i ? tdo_i : 1'bx;
        #1;
        tck_o = 1'b0;
    endtask : bit_cyc

    // test reset pulse, long enough for the block's synchroniser
    task automatic pulse_reset();
        trst_n_o = 1'b0;
        #240;
        trst_n_o = 1'b1;
        #120;
    endtask : pulse_reset
endmodule : bstap_jtag_model

// ---- verif/bstap_tap_tb.sv ----
`timescale 1ns/1ps
`include "bstap_params.svh"
module bstap_tap_tb;
    localparam int N = `BSTAP_BSR_LEN;
    localparam logic [3:0] VER = 4'h6; // arbitrary value
    localparam logic [15:0] DEV = 16'h3C5A; // arbitrary value
    localparam logic [10:0] MKR = 11'h1D2; // arbitrary value
    // bypass-path instructions, the last one an unassigned code
    localparam logic [11:0] BYP_CODES = {`BSTAP_OP_CLAMP, `BSTAP_OP_HIGHZ, `BSTAP_OP_BYPASS, 3'h5};
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin mismatches++; \
    $display("mismatch at %0t ns: got %0h expected %0h", $time, got, exp); end end

    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic tck, tms, tdi, trst_n, tdo, tdo_oe, pin_oe_o, in_rst;
    logic [N-1:0] pin_sample_i = '0, core_out_i = '0, samp_v = '0, core_v = '0;
    logic [N-1:0] pin_out_o, held;
    logic core_oe_i = 1'b0, coe_v = 1'b0;
    logic [2:0] instr, code;
    logic [15:0] lfsr = 16'hF4C1;
    logic [127:0] got, pat;
    int mismatches = 0, checked = 0;

    always #10 mclk_i = ~mclk_i;

    // pin-side inputs move a fixed 1 ns after the rising edge, never on it
    always @(posedge mclk_i) begin
        #1;
        pin_sample_i = samp_v;
        core_out_i = core_v;
        core_oe_i = coe_v;
    end

    bstap_jtag_model bstap_jtag_model_inst (.tck_o(tck), .tms_o(tms), .tdi_o(tdi),
        .trst_n_o(trst_n), .tdo_i(tdo), .tdo_oe_i(tdo_oe));

    bstap_tap #(.BSR_LEN(N), .ID_VERSION(VER), .ID_DEVICE(DEV), .ID_MAKER(MKR)) bstap_tap_inst (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i), .test_reset_n_i(trst_n),
        .test_clock_in_i(tck), .test_mode_select_i(tms), .test_serial_in_i(tdi),
        .test_serial_out_o(tdo), .test_serial_out_oe_o(tdo_oe), .pin_sample_i(pin_sample_i),
        .core_out_i(core_out_i), .core_oe_i(core_oe_i), .pin_out_o(pin_out_o),
        .pin_oe_o(pin_oe_o), .instr_o(instr), .in_reset_state_o(in_rst));

    // 16-bit lfsr, fixed start value so runs repeat
    function automatic logic [127:0] rand_vec();
        logic [127:0] v;
        v = '0;
        for (int i = 0; i < 8; i++) begin
            lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
            v = {v[111:0], lfsr};
        end
        return v;
    endfunction : rand_vec

    // expected pin values and enable for an instruction that keeps bypass on the path
    function automatic logic [N-1:0] pin_exp(input logic [2:0] c);
        return (c == `BSTAP_OP_CLAMP) ? held : core_v;
    endfunction : pin_exp

    function automatic logic oe_exp(input logic [2:0] c);
        return (c == `BSTAP_OP_HIGHZ) ? 1'b0 : (c == `BSTAP_OP_CLAMP) ? 1'b1 : coe_v;
    endfunction : oe_exp

    task automatic stop_test();
        if (mismatches == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    // one non-shifting test clock period
    task automatic jt(input logic ms);
        logic b;
        bstap_jtag_model_inst.bit_cyc(ms, ~tdi, b);
    endtask : jt

    // idle to idle scan of n bits, lsb first; detour through pause after bit pz
    task automatic scan(input logic ir, input int n, input logic [127:0] din, input int pz,
            output logic [127:0] dout);
        dout = '0;
        jt(1'b1);
        if (ir)
            jt(1'b1);
        jt(1'b0);
        jt(1'b0);
        for (int i = 0; i < n; i++) begin
            bstap_jtag_model_inst.bit_cyc(i == n - 1 || i == pz, din[i], dout[i]);
            if (i == pz) begin
                jt(1'b0);
                jt(1'b0);
                jt(1'b1);
                jt(1'b0);
            end
        end
        jt(1'b1);
        jt(1'b0);
    endtask : scan

    // load an instruction and check capture value and the new current instruction
    task automatic load_ir(input logic [2:0] c);
        scan(1'b1, 3, {125'h0, c}, 1, got);
        `CHK(got[2:0], `BSTAP_IR_CAPTURE)
        `CHK(got[1:0], 2'h1)
        `CHK(instr, c)
    endtask : load_ir

    // watchdog: the run needs well under 1000 test clock periods
    initial begin
        #500000;
        mismatches++;
        stop_test();
    end

    initial begin
        pat = rand_vec();
        core_v = pat[N-1:0];
        coe_v = pat[127];
        repeat (2) @(posedge mclk_i);
        #1 rst_b_i = 1'b1;
        repeat (6) @(posedge mclk_i);
        #1;
        `CHK(instr, `BSTAP_OP_IDCODE)
        `CHK(in_rst, 1'b1)
        `CHK(pin_out_o, core_v)
        `CHK(pin_oe_o, coe_v)
        // identification code straight from reset, pausing midway
        jt(1'b0);
        scan(1'b0, 32, rand_vec(), 15, got);
        `CHK(got[31:0], {VER, DEV, MKR, 1'b1})
        // sample with preload: snapshot pins, normal outputs undisturbed
        load_ir(`BSTAP_OP_SAMPLE);
        pat = rand_vec();
        samp_v = pat[N-1:0];
        pat = rand_vec();
        #60; // pins settle; stays 1 ns past a clock edge
        scan(1'b0, N, pat, 60, got);
        `CHK(got[N-1:0], samp_v)
        `CHK(pin_out_o, core_v)
        // extest drives the preloaded latches, then captures and updates again
        load_ir(`BSTAP_OP_EXTEST);
        `CHK(pin_out_o, pat[N-1:0])
        `CHK(pin_oe_o, 1'b1)
        pat = rand_vec();
        samp_v = pat[N-1:0];
        pat = rand_vec();
        #60;
        scan(1'b0, N, pat, -1, got);
        `CHK(got[N-1:0], samp_v)
        `CHK(pin_out_o, pat[N-1:0])
        held = pat[N-1:0];
        // single-stage bypass path for clamp, highz, bypass and an unknown code
        for (int k = 3; k >= 0; k--) begin
            code = BYP_CODES[3*k +: 3];
            load_ir(code);
            pat = rand_vec();
            core_v = pat[N-1:0];
            coe_v = pat[127];
            pat = rand_vec();
            #60;
            scan(1'b0, 8, pat, -1, got);
            `CHK(got[7:0], {pat[6:0], 1'b0})
            `CHK(pin_oe_o, oe_exp(code))
            `CHK(pin_out_o, pin_exp(code))
        end
        // select-ir with mode select high returns to test-logic-reset
        jt(1'b1);
        jt(1'b1);
        jt(1'b1);
        jt(1'b1);
        `CHK(in_rst, 1'b1)
        `CHK(instr, `BSTAP_OP_IDCODE)
        // test reset pin while another instruction is current
        jt(1'b0);
        load_ir(`BSTAP_OP_BYPASS);
        `CHK(in_rst, 1'b0)
        bstap_jtag_model_inst.pulse_reset();
        `CHK(in_rst, 1'b1)
        `CHK(instr, `BSTAP_OP_IDCODE)
        stop_test();
    end
endmodule : bstap_tap_tb
